// ==== src/rfpg_pkg.sv ====
// rfpg_pkg: constants, pattern codes, carrier structs and shared arithmetic
// for the ramp and flat-field pattern generator.
// assumes: a single pixel clock domain; sample codes up to 12 bits wide.
package rfpg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and carriers
  localparam int SW  = 12;
  localparam int PW  = 12;
  localparam int PTW = 5;

  typedef struct packed {
    logic valid;
    logic sof;
    logic sol;
  } rfpg_beat_t;

  typedef struct packed {
    logic [PTW-1:0] pattern;
    logic           depth12;
    logic           enh_present;
  } rfpg_ctl_t;

  typedef struct packed {
    logic          valid;
    logic          sof;
    logic          sol;
    logic [SW-1:0] ch0;
    logic [SW-1:0] ch1;
    logic [SW-1:0] ch2;
  } rfpg_pix_t;

  ////////////////////////////////////////////////////////////////////////////
  // pattern index codes
  localparam logic [PTW-1:0] PAT_LIMIT_RAMP    = 5'h00;
  localparam logic [PTW-1:0] PAT_SHALLOW_MTX   = 5'h01;
  localparam logic [PTW-1:0] PAT_COLOUR_MTX    = 5'h02;
  localparam logic [PTW-1:0] PAT_FLAT_BLACK    = 5'h03;
  localparam logic [PTW-1:0] PAT_FLAT_HALF     = 5'h04;
  localparam logic [PTW-1:0] PAT_FLAT_WHITE    = 5'h05;
  localparam logic [PTW-1:0] PAT_COL100_FIRST  = 5'h06;
  localparam logic [PTW-1:0] PAT_MONO_ENH_FIRST = 5'h0c;
  localparam logic [PTW-1:0] PAT_COL75_FIRST   = 5'h14;
  localparam logic [PTW-1:0] PAT_LAST          = 5'h19;
  localparam logic [PTW-1:0] PAT_RESET         = PAT_FLAT_BLACK;

  ////////////////////////////////////////////////////////////////////////////
  // code levels, 10-bit and 12-bit
  localparam int LIM_LO_10   = 4;
  localparam int LIM_HI_10   = 1019;
  localparam int VAL_LO_10   = 64;
  localparam int VAL_HI_Y_10 = 940;
  localparam int VAL_HI_C_10 = 960;
  localparam int BLANK_10    = 64;
  localparam int LIM_LO_12   = 16;
  localparam int LIM_HI_12   = 4079;
  localparam int VAL_LO_12   = 256;
  localparam int VAL_HI_Y_12 = 3760;
  localparam int VAL_HI_C_12 = 3840;
  localparam int BLANK_12    = 256;

  ////////////////////////////////////////////////////////////////////////////
  // pattern geometry
  localparam int RAMP_PLAT_W = 32;
  localparam int SRM_BANDS   = 10;
  localparam int SRM_HOLD_10 = 4;
  localparam int SRM_HOLD_12 = 2;
  localparam int SRM_OVL_10  = 16;
  localparam int SRM_OVL_12  = 64;
  localparam int CRM_BANDS   = 8;
  localparam int CRM_SEGS    = 6;
  localparam int PCT_FULL    = 100;
  localparam int PCT_COL_ENH = 75;

  ////////////////////////////////////////////////////////////////////////////
  // shared arithmetic
  function automatic logic [SW-1:0] to_code(input int v);
    to_code = SW'(v);
  endfunction

  // percentage of the valid span above black, same on every channel
  function automatic logic [SW-1:0] pct_level(input int pct, input logic d12);
    int lo;
    int hi;
    lo = d12 ? VAL_LO_12 : VAL_LO_10;
    hi = d12 ? VAL_HI_Y_12 : VAL_HI_Y_10;
    pct_level = to_code(lo + (pct * (hi - lo)) / PCT_FULL);
  endfunction

  // rgb on-mask of the six flat-field colours: r g b c m y
  function automatic logic [2:0] flat_mask(input int idx);
    case (idx)
      0:       flat_mask = 3'b100;
      1:       flat_mask = 3'b010;
      2:       flat_mask = 3'b001;
      3:       flat_mask = 3'b011;
      4:       flat_mask = 3'b101;
      default: flat_mask = 3'b110;
    endcase
  endfunction

  // hue corners of the colour matrix: r y g c m b r
  function automatic logic [2:0] hue_mask(input int k);
    case (k)
      0:       hue_mask = 3'b100;
      1:       hue_mask = 3'b110;
      2:       hue_mask = 3'b010;
      3:       hue_mask = 3'b011;
      4:       hue_mask = 3'b101;
      5:       hue_mask = 3'b001;
      default: hue_mask = 3'b100;
    endcase
  endfunction

endpackage

// ==== src/rfpg_band.sv ====
// rfpg_band: counts unit steps into bands of a fixed size and reports the
// band and the position inside it for the current step.
// assumes: restart and step come from logic on the same clock.
`timescale 1ns/1ps
module rfpg_band #(
  parameter int BAND_SZ = 108,
  parameter int NBANDS  = 10
) (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire logic                    restart,
  input  wire logic                    step,
  output logic [3:0]                   band_cur,
  output logic [rfpg_pkg::PW-1:0]      pos_cur
);

  logic [3:0]              band_reg;
  logic [rfpg_pkg::PW-1:0] pos_reg;
  logic                    wrap;
  logic                    last_band;

  ////////////////////////////////////////////////////////////////////////////
  // decode; the last band stretches if the frame is taller than planned
  assign wrap      = (pos_reg == rfpg_pkg::PW'(BAND_SZ - 1));
  assign last_band = (band_reg == 4'(NBANDS - 1));
  assign band_cur  = restart ? 4'h0 :
                     (step && wrap && !last_band) ? band_reg + 4'h1 : band_reg;
  assign pos_cur   = restart ? '0 :
                     step ? (wrap ? '0 : pos_reg + rfpg_pkg::PW'(1)) : pos_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      band_reg <= 4'h0;
      pos_reg  <= '0;
    end
    else
    begin
      band_reg <= band_cur;
      pos_reg  <= pos_cur;
    end
  end

endmodule // rfpg_band

// ==== src/rfpg_flat.sv ====
// rfpg_flat: component codes of the full-frame flat fields.
// assumes: the pattern index has already been screened for the enhanced set.
`timescale 1ns/1ps
module rfpg_flat (
  input  wire logic [rfpg_pkg::PTW-1:0] pattern,
  input  wire logic                     depth12,
  output logic [rfpg_pkg::SW-1:0]       ch0,
  output logic [rfpg_pkg::SW-1:0]       ch1,
  output logic [rfpg_pkg::SW-1:0]       ch2
);

  logic                     is_col100;
  logic                     is_col75;
  logic                     is_mono_enh;
  logic [rfpg_pkg::PTW-1:0] sub;
  logic [2:0]               mask;
  logic [6:0]               mono_pct;
  logic [6:0]               col_pct;
  logic [rfpg_pkg::SW-1:0]  on_code;
  logic [rfpg_pkg::SW-1:0]  off_code;

  ////////////////////////////////////////////////////////////////////////////
  assign is_col100   = pattern >= rfpg_pkg::PAT_COL100_FIRST && pattern < rfpg_pkg::PAT_MONO_ENH_FIRST;
  assign is_mono_enh = pattern >= rfpg_pkg::PAT_MONO_ENH_FIRST && pattern < rfpg_pkg::PAT_COL75_FIRST;
  assign is_col75    = pattern >= rfpg_pkg::PAT_COL75_FIRST;
  assign sub         = is_col75 ? pattern - rfpg_pkg::PAT_COL75_FIRST :
                       is_mono_enh ? pattern - rfpg_pkg::PAT_MONO_ENH_FIRST :
                       pattern - rfpg_pkg::PAT_COL100_FIRST;
  assign mask        = rfpg_pkg::flat_mask(int'(sub));

  // enhanced grey steps skip 50, which the base set already carries
  assign mono_pct = (pattern == rfpg_pkg::PAT_FLAT_BLACK) ? 7'h00 :
                    (pattern == rfpg_pkg::PAT_FLAT_HALF)  ? 7'h32 :
                    (pattern == rfpg_pkg::PAT_FLAT_WHITE) ? 7'h64 :
                    (sub < 5'h04) ? 7'(10 * (int'(sub) + 1)) :
                    7'(10 * (int'(sub) + 2));
  assign col_pct  = is_col75 ? 7'(rfpg_pkg::PCT_COL_ENH) : 7'(rfpg_pkg::PCT_FULL);

  assign on_code  = rfpg_pkg::pct_level(int'(col_pct), depth12);
  assign off_code = rfpg_pkg::pct_level(0, depth12);

  ////////////////////////////////////////////////////////////////////////////
  // colour fields put col_pct (100, or 75 for the enhanced set) on the lit channels, black on the others
  always_comb
  begin
    if (is_col100 || is_col75)
    begin
      ch0 = mask[2] ? on_code : off_code;
      ch1 = mask[1] ? on_code : off_code;
      ch2 = mask[0] ? on_code : off_code;
    end
    else
    begin
      ch0 = rfpg_pkg::pct_level(int'(mono_pct), depth12);
      ch1 = ch0;
      ch2 = ch0;
    end
  end

endmodule // rfpg_flat

// ==== src/rfpg_top.sv ====
// rfpg_top: per-pixel component generator for ramp and flat-field patterns.
// assumes: beat and control come from the timing logic on the same clock;
// sof marks the first pixel of a frame, sol the first pixel of every line.
`timescale 1ns/1ps
module rfpg_top #(
  parameter int ACT_W = 1920,
  parameter int ACT_H = 1080
) (
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire rfpg_pkg::rfpg_beat_t     beat_in,
  input  wire rfpg_pkg::rfpg_ctl_t      ctl_in,
  output rfpg_pkg::rfpg_pix_t           pix_out,
  output logic [rfpg_pkg::PTW-1:0]      active_pattern,
  output logic                          active_depth12,
  output logic                          select_refused
);

  localparam int PLAT_W = rfpg_pkg::RAMP_PLAT_W;
  localparam int RAMP_W = ACT_W - 6 * PLAT_W;
  localparam int SEG_W  = ACT_W / rfpg_pkg::CRM_SEGS;

  ////////////////////////////////////////////////////////////////////////////
  // colour matrix component: c is the unit colour over 0..SEG_W
  function automatic logic [rfpg_pkg::SW-1:0] crm_code(input int c, input int f, input int row,
                                                        input logic d12);
    int lo;
    int hi;
    int w;
    lo = d12 ? rfpg_pkg::VAL_LO_12 : rfpg_pkg::VAL_LO_10;
    hi = d12 ? rfpg_pkg::VAL_HI_Y_12 : rfpg_pkg::VAL_HI_Y_10;
    case (row)
      0:       w = 100 * SEG_W - 25 * (SEG_W - c);
      1:       w = 100 * SEG_W - 50 * (SEG_W - c);
      2:       w = 100 * SEG_W - 75 * (SEG_W - c);
      3:       w = 100 * c;
      4:       w = 75 * c;
      5:       w = 50 * c;
      6:       w = 25 * c;
      default: w = 100 * f;
    endcase
    crm_code = rfpg_pkg::to_code(lo + (w * (hi - lo)) / (100 * SEG_W));
  endfunction

  // unit colour of one channel blended between two hue corners
  function automatic int blend(input logic s_on, input logic e_on, input int f);
    blend = (s_on ? SEG_W - f : 0) + (e_on ? f : 0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  rfpg_pkg::rfpg_pix_t      pix_reg;
  rfpg_pkg::rfpg_pix_t      pix_next;
  logic [rfpg_pkg::PTW-1:0] pat_reg;
  logic [rfpg_pkg::PTW-1:0] pat_cur;
  logic                     d12_reg;
  logic                     d12_cur;
  logic                     refused_reg;
  logic                     refused_next;
  logic [rfpg_pkg::PW-1:0]  x_reg;
  logic [rfpg_pkg::PW-1:0]  x_cur;
  logic                     frame_start;
  logic                     line_start;
  logic                     pix_step;
  logic                     enh_only;
  logic                     bad_sel;
  logic [3:0]               srm_band;
  logic [3:0]               crm_band;
  logic [3:0]               crm_seg;
  logic [rfpg_pkg::PW-1:0]  crm_f;
  logic [rfpg_pkg::SW-1:0]  lim_lo;
  logic [rfpg_pkg::SW-1:0]  lim_hi;
  logic [rfpg_pkg::SW-1:0]  val_lo;
  logic [rfpg_pkg::SW-1:0]  val_hi_y;
  logic [rfpg_pkg::SW-1:0]  val_hi_c;
  logic [rfpg_pkg::SW-1:0]  blank;
  logic [rfpg_pkg::SW-1:0]  ramp_code;
  logic [rfpg_pkg::SW-1:0]  lr_y;
  logic [rfpg_pkg::SW-1:0]  lr_c;
  logic                     in_ramp;
  logic [rfpg_pkg::SW-1:0]  srm_start;
  logic [rfpg_pkg::SW+3:0]  srm_raw;
  logic [rfpg_pkg::SW-1:0]  srm_code;
  logic [2:0]               hue_s;
  logic [2:0]               hue_e;
  logic [rfpg_pkg::SW-1:0]  crm_r;
  logic [rfpg_pkg::SW-1:0]  crm_g;
  logic [rfpg_pkg::SW-1:0]  crm_b;
  logic [rfpg_pkg::SW-1:0]  flat_r;
  logic [rfpg_pkg::SW-1:0]  flat_g;
  logic [rfpg_pkg::SW-1:0]  flat_b;

  ////////////////////////////////////////////////////////////////////////////
  // frame-level selection
  assign pix_step    = beat_in.valid;
  assign frame_start = beat_in.valid && beat_in.sof;
  assign line_start  = beat_in.valid && (beat_in.sol || beat_in.sof);

  assign enh_only = ctl_in.pattern >= rfpg_pkg::PAT_MONO_ENH_FIRST;
  // an undefined index is turned away the same way as a missing enhanced set
  assign bad_sel  = (enh_only && !ctl_in.enh_present) || ctl_in.pattern > rfpg_pkg::PAT_LAST;

  // control is sampled only on the first pixel, so mid-frame changes wait
  assign pat_cur      = (frame_start && !bad_sel) ? ctl_in.pattern : pat_reg;
  assign d12_cur      = frame_start ? ctl_in.depth12 : d12_reg;
  assign refused_next = frame_start ? bad_sel : refused_reg;

  assign x_cur = line_start ? '0 : x_reg;

  ////////////////////////////////////////////////////////////////////////////
  // vertical and horizontal banding
  rfpg_band #(
    .BAND_SZ (ACT_H / rfpg_pkg::SRM_BANDS),
    .NBANDS  (rfpg_pkg::SRM_BANDS)
  ) u_srm_rows (
    .clock    (clock),
    .reset    (reset),
    .restart  (frame_start),
    .step     (line_start),
    .band_cur (srm_band),
    .pos_cur  ()
  );

  rfpg_band #(
    .BAND_SZ (ACT_H / rfpg_pkg::CRM_BANDS),
    .NBANDS  (rfpg_pkg::CRM_BANDS)
  ) u_crm_rows (
    .clock    (clock),
    .reset    (reset),
    .restart  (frame_start),
    .step     (line_start),
    .band_cur (crm_band),
    .pos_cur  ()
  );

  // line start restarts the segment counter on the first pixel itself
  rfpg_band #(
    .BAND_SZ (SEG_W),
    .NBANDS  (rfpg_pkg::CRM_SEGS)
  ) u_crm_segs (
    .clock    (clock),
    .reset    (reset),
    .restart  (line_start),
    .step     (pix_step),
    .band_cur (crm_seg),
    .pos_cur  (crm_f)
  );

  ////////////////////////////////////////////////////////////////////////////
  // level set for the frame's depth
  assign lim_lo   = rfpg_pkg::to_code(d12_cur ? rfpg_pkg::LIM_LO_12 : rfpg_pkg::LIM_LO_10);
  assign lim_hi   = rfpg_pkg::to_code(d12_cur ? rfpg_pkg::LIM_HI_12 : rfpg_pkg::LIM_HI_10);
  assign val_lo   = rfpg_pkg::to_code(d12_cur ? rfpg_pkg::VAL_LO_12 : rfpg_pkg::VAL_LO_10);
  assign val_hi_y = rfpg_pkg::to_code(d12_cur ? rfpg_pkg::VAL_HI_Y_12 : rfpg_pkg::VAL_HI_Y_10);
  assign val_hi_c = rfpg_pkg::to_code(d12_cur ? rfpg_pkg::VAL_HI_C_12 : rfpg_pkg::VAL_HI_C_10);
  assign blank    = rfpg_pkg::to_code(d12_cur ? rfpg_pkg::BLANK_12 : rfpg_pkg::BLANK_10);

  ////////////////////////////////////////////////////////////////////////////
  // limit ramp: three plateaus, ramp, three plateaus mirrored
  assign in_ramp   = x_cur >= rfpg_pkg::PW'(3 * PLAT_W) && x_cur < rfpg_pkg::PW'(ACT_W - 3 * PLAT_W);
  assign ramp_code = rfpg_pkg::to_code(int'(lim_lo) +
                     ((int'(x_cur) - 3 * PLAT_W) * (int'(lim_hi) - int'(lim_lo))) / (RAMP_W - 1));

  always_comb
  begin
    lr_y = blank;
    lr_c = blank;
    if (x_cur < rfpg_pkg::PW'(PLAT_W))
    begin
      lr_y = blank;
      lr_c = blank;
    end
    else if (x_cur < rfpg_pkg::PW'(2 * PLAT_W))
    begin
      lr_y = val_lo;
      lr_c = val_lo;
    end
    else if (x_cur < rfpg_pkg::PW'(3 * PLAT_W))
    begin
      lr_y = lim_lo;
      lr_c = lim_lo;
    end
    else if (in_ramp)
    begin
      lr_y = ramp_code;
      lr_c = ramp_code;
    end
    else if (x_cur < rfpg_pkg::PW'(ACT_W - 2 * PLAT_W))
    begin
      lr_y = lim_hi;
      lr_c = lim_hi;
    end
    else if (x_cur < rfpg_pkg::PW'(ACT_W - PLAT_W))
    begin
      lr_y = val_hi_y;
      lr_c = val_hi_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shallow matrix: row start advances by less than a row's span
  assign srm_start = rfpg_pkg::to_code(int'(lim_lo) + int'(srm_band) *
                     (d12_cur ? (ACT_W / 4 - rfpg_pkg::SRM_OVL_12)
                              : (ACT_W / 16 - rfpg_pkg::SRM_OVL_10)));
  assign srm_raw   = {4'h0, srm_start} +
                     {4'h0, (d12_cur ? (x_cur >> rfpg_pkg::SRM_HOLD_12) : (x_cur >> rfpg_pkg::SRM_HOLD_10))};
  // last rows would run past the limit, so they stop at it
  assign srm_code  = (srm_raw > {4'h0, lim_hi}) ? lim_hi : srm_raw[rfpg_pkg::SW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // colour matrix: blend hue corners, then shape by row
  assign hue_s = rfpg_pkg::hue_mask(int'(crm_seg));
  assign hue_e = rfpg_pkg::hue_mask(int'(crm_seg) + 1);
  assign crm_r = crm_code(blend(hue_s[2], hue_e[2], int'(crm_f)), int'(crm_f), int'(crm_band), d12_cur);
  assign crm_g = crm_code(blend(hue_s[1], hue_e[1], int'(crm_f)), int'(crm_f), int'(crm_band), d12_cur);
  assign crm_b = crm_code(blend(hue_s[0], hue_e[0], int'(crm_f)), int'(crm_f), int'(crm_band), d12_cur);

  ////////////////////////////////////////////////////////////////////////////
  // flat fields
  rfpg_flat u_flat (
    .pattern (pat_cur),
    .depth12 (d12_cur),
    .ch0     (flat_r),
    .ch1     (flat_g),
    .ch2     (flat_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pattern select
  always_comb
  begin
    pix_next       = pix_reg;
    pix_next.valid = beat_in.valid;
    pix_next.sof   = beat_in.valid && beat_in.sof;
    pix_next.sol   = beat_in.valid && (beat_in.sol || beat_in.sof);
    if (beat_in.valid)
    begin
      case (pat_cur)
        rfpg_pkg::PAT_LIMIT_RAMP:
        begin
          pix_next.ch0 = lr_y;
          pix_next.ch1 = lr_c;
          pix_next.ch2 = lr_c;
        end
        rfpg_pkg::PAT_SHALLOW_MTX:
        begin
          pix_next.ch0 = srm_code;
          pix_next.ch1 = srm_code;
          pix_next.ch2 = srm_code;
        end
        rfpg_pkg::PAT_COLOUR_MTX:
        begin
          pix_next.ch0 = crm_r;
          pix_next.ch1 = crm_g;
          pix_next.ch2 = crm_b;
        end
        default:
        begin
          pix_next.ch0 = flat_r;
          pix_next.ch1 = flat_g;
          pix_next.ch2 = flat_b;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pix_reg     <= '0;
      pat_reg     <= rfpg_pkg::PAT_RESET;
      d12_reg     <= 1'b0;
      refused_reg <= 1'b0;
      x_reg       <= '0;
    end
    else
    begin
      pix_reg     <= pix_next;
      pat_reg     <= pat_cur;
      d12_reg     <= d12_cur;
      refused_reg <= refused_next;
      x_reg       <= pix_step ? x_cur + rfpg_pkg::PW'(1) : x_reg;
    end
  end

  assign pix_out        = pix_reg;
  assign active_pattern = pat_reg;
  assign active_depth12 = d12_reg;
  assign select_refused = refused_reg;

endmodule // rfpg_top

// ==== tb/rfpg_sink.sv ====
// rfpg_sink: serializer stand-in, counts pixel position along the line.
// assumes: pix_out of the generator, one pixel per valid cycle.
`timescale 1ns/1ps
module rfpg_sink (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire rfpg_pkg::rfpg_pix_t pix,
  output logic [11:0]              pos_x
);
  logic [11:0] cnt_reg;

  // position is combinational so it lines up with the pixel it names
  assign pos_x = pix.sol ? 12'h000 : cnt_reg;

  always_ff @(posedge clock or posedge reset)
    if (reset)
      cnt_reg <= 12'h000;
    else if (pix.valid)
      cnt_reg <= pos_x + 12'h001;
endmodule // rfpg_sink

// ==== tb/rfpg_top_props.sv ====
// rfpg_top_props: port-level checks of the pattern generator.
// assumes: single clock, async active-high reset.
`timescale 1ns/1ps
module rfpg_top_props (
  input wire logic                     clock,
  input wire logic                     reset,
  input wire rfpg_pkg::rfpg_beat_t     beat_in,
  input wire rfpg_pkg::rfpg_ctl_t      ctl_in,
  input wire rfpg_pkg::rfpg_pix_t      pix_out,
  input wire logic [rfpg_pkg::PTW-1:0] active_pattern,
  input wire logic                     active_depth12,
  input wire logic                     select_refused
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic take;
  logic pv;
  logic d;
  assign take = beat_in.valid && beat_in.sof;
  assign pv   = pix_out.valid;
  assign d    = active_depth12;
  ////////////////////////////////////////////////////////////
  a_frame_mark: assert property (take |=> pv && pix_out.sof && pix_out.sol)
    else $error("frame start not marked");
  a_refuse_enh: assert property (take && ctl_in.pattern >= 5'h0c && !ctl_in.enh_present
    |=> select_refused && active_pattern == $past(active_pattern)) else $error("enhanced pick not refused");
  a_accept_base: assert property (take && ctl_in.pattern < 5'h0c
    |=> !select_refused && active_pattern == $past(ctl_in.pattern)) else $error("base pick not taken");
  a_ctl_steady: assert property (!take |=> $stable(active_pattern) && $stable(select_refused) && $stable(d))
    else $error("control moved mid frame");
  a_ramp_limits: assert property (pv && active_pattern == 5'h00
    |-> pix_out.ch0 >= (d ? 16 : 4) && pix_out.ch0 <= (d ? 4079 : 1019)) else $error("ramp out of limits");
  a_ramp_chroma: assert property (pv && active_pattern == 5'h00 |-> pix_out.ch1 == pix_out.ch2)
    else $error("ramp chroma differ");
  a_flat_white: assert property (pv && active_pattern == 5'h05
    |-> {pix_out.ch0, pix_out.ch1, pix_out.ch2} == {3{d ? 12'heb0 : 12'h3ac}}) else $error("white level");
  a_grey_equal: assert property (pv && active_pattern inside {[5'h03:5'h05], [5'h0c:5'h13]}
    |-> pix_out.ch0 == pix_out.ch1 && pix_out.ch1 == pix_out.ch2) else $error("grey field not grey");
  a_red75_level: assert property (pv && active_pattern == 5'h14
    |-> pix_out.ch0 == (d ? 2884 : 721) && pix_out.ch1 == (d ? 256 : 64)) else $error("red field level");
  a_colour_gamut: assert property (pv && active_pattern == 5'h02
    |-> pix_out.ch0 >= (d ? 256 : 64) && pix_out.ch0 <= (d ? 3760 : 940) && pix_out.ch1 >= (d ? 256 : 64)
    && pix_out.ch1 <= (d ? 3760 : 940) && pix_out.ch2 >= (d ? 256 : 64) && pix_out.ch2 <= (d ? 3760 : 940))
    else $error("colour ramp outside gamut");
  a_colour_corner: assert property (pv && pix_out.sof && active_pattern == 5'h02
    |-> pix_out.ch0 == (d ? 3760 : 940) && pix_out.ch1 == (d ? 2884 : 721) && pix_out.ch2 == pix_out.ch1)
    else $error("colour matrix top corner");
  c_refused: cover property (take && ctl_in.pattern >= 5'h0c && !ctl_in.enh_present);
  c_ramp12: cover property (pv && active_pattern == 5'h00 && d);
  c_red75: cover property (pv && active_pattern == 5'h14);
  c_colour: cover property (pv && active_pattern == 5'h02);
endmodule // rfpg_top_props

bind rfpg_top rfpg_top_props u_props (.clock(clock), .reset(reset), .beat_in(beat_in), .ctl_in(ctl_in),
  .pix_out(pix_out), .active_pattern(active_pattern), .active_depth12(active_depth12),
  .select_refused(select_refused));

// ==== tb/rfpg_top_bench.sv ====
// rfpg_top_bench: frames of every pattern code, random depth, gaps and noise.
// assumes: two-line frames suffice; they never leave the top band of either matrix.
`timescale 1ns/1ps
module rfpg_top_bench;
  localparam int W = 256;
  logic                 clock;
  logic                 reset;
  rfpg_pkg::rfpg_beat_t beat_in;
  rfpg_pkg::rfpg_ctl_t  ctl_in;
  rfpg_pkg::rfpg_pix_t  pix_out;
  logic [4:0]           active_pattern;
  logic                 active_depth12;
  logic                 select_refused;
  logic [11:0]          pos_x;
  int                   fails, samples_checked, seed, exp_p, nxt_p;
  bit                   exp_d, exp_r, nxt_d, nxt_e;
  ////////////////////////////////////////////////////////////
  rfpg_top #(.ACT_W(W), .ACT_H(80)) u_dut (.clock(clock), .reset(reset), .beat_in(beat_in), .ctl_in(ctl_in),
    .pix_out(pix_out), .active_pattern(active_pattern), .active_depth12(active_depth12),
    .select_refused(select_refused));
  rfpg_sink u_sink (.clock(clock), .reset(reset), .pix(pix_out), .pos_x(pos_x));
  initial
  begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  function automatic int exp_code(int p, bit d, int x, int c);
    int lo, hi, ll, lh, pct, k, f, u;
    bit [2:0] m, s;
    lo = d ? 256 : 64;
    hi = d ? 3760 : 940;
    ll = d ? 16 : 4;
    lh = d ? 4079 : 1019;
    if (p == 0)
    begin
      if (x < 64 || x >= W - 32) return lo;
      if (x < 96) return ll;
      if (x < W - 96) return ll + (x - 96) * (lh - ll) / (W - 193);
      if (x < W - 64) return lh;
      return (c == 0) ? hi : (d ? 3840 : 960);
    end
    if (p == 1) return ll + (d ? x / 4 : x / 16);
    // colour matrix, top row only: 25% saturation between hue corners r y g c m b r
    if (p == 2)
    begin
      k = x / (W / 6) > 5 ? 5 : x / (W / 6);
      f = x % (W / 6);
      s = 3'(21'o4623514 >> (3 * (6 - k)));
      m = 3'(21'o4623514 >> (3 * (5 - k)));
      u = (s[2 - c] ? W / 6 - f : 0) + (m[2 - c] ? f : 0);
      return lo + (100 * (W / 6) - 25 * (W / 6 - u)) * (hi - lo) / (100 * (W / 6));
    end
    pct = p < 6 ? (p - 3) * 50 : p < 12 ? 100 : p < 20 ? (p - 11 + (p >= 16)) * 10 : 75;
    k = p < 12 ? p - 6 : p - 20;
    // colour mask r,g,b,c,m,y with red on ch0
    m = (p < 6 || (p >= 12 && p < 20)) ? 3'b111 : 3'(18'o421356 >> (3 * (5 - k)));
    return m[2 - c] ? lo + pct * (hi - lo) / 100 : lo;
  endfunction

  task automatic check(string what, logic [11:0] seen, logic [11:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // mid-frame control is noise on purpose: it must not leak into the frame
  task automatic frame(int p, bit d, bit e);
    for (int n = 0; n < 2 * W; n++)
    begin
      @(posedge clock);
      beat_in <= '{1'b1, n == 0, n % W == 0};
      if (n == 0)
        ctl_in <= '{5'(p), d, e};
      else
        ctl_in <= rfpg_pkg::rfpg_ctl_t'($random(seed));
      if (n == 0)
      begin
        nxt_p = p;
        nxt_d = d;
        nxt_e = e;
      end
      if (($random(seed) & 7) == 0)
      begin
        @(posedge clock);
        beat_in <= '0;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////
  always @(negedge clock)
    if (!reset && pix_out.valid)
    begin
      if (pix_out.sof)
      begin
        exp_r = (nxt_p >= 12 && !nxt_e) || nxt_p > 25;
        if (!exp_r) exp_p = nxt_p;
        exp_d = nxt_d;
        check("refused", 12'(select_refused), 12'(exp_r));
        check("pattern", 12'(active_pattern), 12'(exp_p));
        check("depth", 12'(active_depth12), 12'(exp_d));
      end
      for (int c = 0; c < 3; c++)
        check("channel", c == 0 ? pix_out.ch0 : c == 1 ? pix_out.ch1 : pix_out.ch2,
          12'(exp_code(exp_p, exp_d, int'(pos_x), c)));
    end

  initial
  begin
    #2400000;
    fails++;
    stop_test();
  end

  initial
  begin
    seed = 32'h31047ee5;
    reset = 1;
    beat_in = '0;
    ctl_in = '0;
    exp_p = 3;
    repeat (4) @(posedge clock);
    check("reset pattern", 12'(active_pattern), 12'h003);
    reset <= 0;
    // every code with the set installed, then every code without it, then noise
    for (int i = 0; i < 60; i++)
      frame(i < 52 ? i % 26 : $random(seed) & 31, $random(seed) & 1, i < 26 ? 1'b1 : i < 52 ? 1'b0 : $random(seed) & 1);
    @(posedge clock);
    beat_in <= '0;
    repeat (3) @(posedge clock);
    stop_test();
  end
endmodule // rfpg_top_bench
